// file: cid_alu.sv
// Eight-bit adder and left shifter with condition flag generation.
// Purely combinational; the caller selects which flags it keeps.
`timescale 1ns/10ps
module cid_alu (
  // Operands
  input wire logic [7:0] a_in,
  input wire logic [7:0] m_in,
  input wire logic carry_in,
  // Operation select, high for the left shift
  input wire logic shift_sel,
  // Result and flags
  output cid_pkg::cid_alu_t result
);

  logic [4:0] low_sum; // Nibble sum, bit 4 is the half carry
  logic [8:0] full_sum; // Byte sum, bit 8 is the carry

  // Result and flag generation
  always_comb
  begin
    low_sum = {1'b0, a_in[3:0]} + {1'b0, m_in[3:0]} + {4'h0, carry_in};
    full_sum = {1'b0, a_in} + {1'b0, m_in} + {8'h00, carry_in};
    if (shift_sel)
    begin
      // Top bit leaves into carry, zero enters at the bottom
      result.res = {a_in[6:0], 1'b0};
      result.c = a_in[7];
      result.h = 1'b0;
      // Overflow equals new sign xor carry, i.e. old bits 7 and 6 differ
      result.v = a_in[7] ^ a_in[6];
    end
    else
    begin
      result.res = full_sum[7:0];
      result.c = full_sum[8];
      result.h = low_sum[4];
      // Like signs in, different sign out
      result.v = (a_in[7] == m_in[7]) && (full_sum[7] != a_in[7]);
    end
    result.n = result.res[7];
    result.z = (result.res == 8'h00);
  end

endmodule

// file: cid_core.sv
// Decode and execute front end of an 8-bit accumulator core, with an APB register port.
// Assumes a byte-wide memory on CLK_SYS whose read data follows MEM_ADDR in the cycle
// in which MEM_RD stands, and an APB master on the same clock.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module cid_core #(
  parameter int unsigned BUS_DIV = 4 // System clocks per bus cycle, at least 4
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // APB register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Program and data memory
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  // Instruction completion pulse
  output logic RETIRE
);

  // One-hot sequencer states
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_OP = 7'b0000010,
    S_B1 = 7'b0000100,
    S_B2 = 7'b0001000,
    S_ADR = 7'b0010000,
    S_EXE = 7'b0100000,
    S_PAD = 7'b1000000
  } cid_state_t;

  cid_state_t state_reg; // Sequencer state
  cid_pkg::cid_dec_t dec_reg; // Decoded current instruction
  cid_pkg::cid_dec_t dec_now; // Decode of the byte on the memory bus
  cid_pkg::cid_alu_t alu_res; // Adder or shifter result
  logic pre_reg; // Stack prefix seen
  logic [7:0] b1_reg; // First operand byte
  logic [7:0] b2_reg; // Second operand byte
  logic [15:0] ea_reg; // Effective address
  logic [15:0] ea_now; // Effective address being formed
  logic [2:0] bus_cnt_reg; // Bus cycles elapsed in this instruction
  logic [$clog2(BUS_DIV)-1:0] div_reg; // Bus cycle divider
  logic tick_reg; // One-cycle bus cycle enable
  logic [7:0] acc_reg; // Accumulator
  logic [15:0] hx_reg; // Index pair
  logic [15:0] sp_reg; // Stack pointer
  logic [15:0] pc_reg; // Program counter
  logic [7:0] cf_reg; // condition_flags
  logic run_reg; // Software run enable
  logic bad_reg; // Sticky unknown opcode flag
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic [15:0] mem_addr_reg;
  logic mem_rd_reg, mem_wr_reg, retire_reg;
  logic [7:0] mem_wdata_reg;
  logic is_prefix, bad_set, start_ok, last_tick, fetch_rd, mem_mode, halted;
  logic apb_setup, apb_wr, addr_hit;
  logic [31:0] rd_mux;
  logic [7:0] alu_a, alu_m, rel_off;

  // Divider: one enable pulse every BUS_DIV system clocks
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (div_reg == $clog2(BUS_DIV)'(BUS_DIV - 1))
    begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      div_reg <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // Sequencing conditions and effective address
  always_comb
  begin
    dec_now = cid_pkg::cid_decode(pre_reg, MEM_RDATA);
    start_ok = run_reg && !bad_reg;
    halted = (state_reg == S_IDLE) && !run_reg;
    is_prefix = (state_reg == S_OP) && !pre_reg && (MEM_RDATA == cid_pkg::OP_PREFIX_STACK);
    bad_set = (state_reg == S_OP) && !is_prefix && (dec_now.kind == cid_pkg::K_BAD);
    // Instruction ends on the bus cycle its count allows
    last_tick = tick_reg && (state_reg == S_PAD) && (bus_cnt_reg + 3'h1 == dec_reg.cycles);
    fetch_rd = (tick_reg && start_ok && (state_reg == S_IDLE)) || (last_tick && start_ok) || is_prefix
      || ((state_reg == S_OP) && !is_prefix && !bad_set && dec_now.nbytes != 2'h0)
      || ((state_reg == S_B1) && dec_reg.nbytes == 2'h2);
    mem_mode = !(dec_reg.mode inside {cid_pkg::MD_IMM, cid_pkg::MD_REL, cid_pkg::MD_INHA,
      cid_pkg::MD_INHX, cid_pkg::MD_NONE});
    case (dec_reg.mode)
      cid_pkg::MD_DIR: ea_now = {cid_pkg::DIRECT_PAGE_HI, b1_reg};
      cid_pkg::MD_EXT: ea_now = {b1_reg, b2_reg};
      cid_pkg::MD_IX2: ea_now = hx_reg + {b1_reg, b2_reg};
      cid_pkg::MD_IX1, cid_pkg::MD_IX1P: ea_now = hx_reg + {8'h00, b1_reg};
      cid_pkg::MD_IX, cid_pkg::MD_IXP: ea_now = hx_reg;
      cid_pkg::MD_SP2: ea_now = sp_reg + {b1_reg, b2_reg};
      cid_pkg::MD_SP1: ea_now = sp_reg + {8'h00, b1_reg};
      default: ea_now = 16'h0000;
    endcase
    // Shift works on its own target; adds work on the accumulator
    if (dec_reg.kind == cid_pkg::K_SHL)
      alu_a = (dec_reg.mode == cid_pkg::MD_INHA) ? acc_reg
        : (dec_reg.mode == cid_pkg::MD_INHX) ? hx_reg[7:0] : MEM_RDATA;
    else
      alu_a = acc_reg;
    alu_m = (dec_reg.mode == cid_pkg::MD_IMM) ? b1_reg : MEM_RDATA;
    // Compare-branch with offset carries its branch byte second
    rel_off = (dec_reg.mode == cid_pkg::MD_IX1P) ? b2_reg : b1_reg;
  end

  // Shared adder and shifter
  cid_alu u_alu (
    .a_in(alu_a),
    .m_in(alu_m),
    .carry_in((dec_reg.kind == cid_pkg::K_ADC) ? cf_reg[cid_pkg::FLG_C] : 1'b0),
    .shift_sel(dec_reg.kind == cid_pkg::K_SHL),
    .result(alu_res)
  );

  // Instruction sequencer and memory strobes
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= S_IDLE;
      dec_reg <= cid_pkg::cid_entry(cid_pkg::K_BAD, cid_pkg::MD_NONE, 2'h0, cid_pkg::CYC_1);
      pre_reg <= 1'b0;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      ea_reg <= 16'h0000;
      bus_cnt_reg <= 3'h0;
      mem_addr_reg <= 16'h0000;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_wdata_reg <= 8'h00;
      retire_reg <= 1'b0;
    end
    else
    begin
      // Strobes clear unless set again; write and retire are one-cycle pulses, reads can run back to back
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      retire_reg <= 1'b0;
      if (tick_reg)
        bus_cnt_reg <= bus_cnt_reg + 3'h1;
      // Instruction stream reads always come from the program counter
      if (fetch_rd)
      begin
        mem_addr_reg <= pc_reg;
        mem_rd_reg <= 1'b1;
      end
      case (state_reg)
        S_IDLE:
          if (tick_reg && start_ok)
          begin
            state_reg <= S_OP;
            pre_reg <= 1'b0;
            bus_cnt_reg <= 3'h0;
          end
        S_OP:
          // Prefix fetches the real opcode next; unknown codes park the core
          if (is_prefix)
            pre_reg <= 1'b1;
          else if (bad_set)
            state_reg <= S_IDLE;
          else
          begin
            dec_reg <= dec_now;
            state_reg <= (dec_now.nbytes != 2'h0) ? S_B1 : S_ADR;
          end
        S_B1:
        begin
          b1_reg <= MEM_RDATA;
          state_reg <= (dec_reg.nbytes == 2'h2) ? S_B2 : S_ADR;
        end
        S_B2:
        begin
          b2_reg <= MEM_RDATA;
          state_reg <= S_ADR;
        end
        S_ADR:
        begin
          ea_reg <= ea_now;
          if (mem_mode)
          begin
            mem_addr_reg <= ea_now;
            mem_rd_reg <= 1'b1;
          end
          state_reg <= S_EXE;
        end
        S_EXE:
        begin
          // Read-modify-write for memory shifts
          if (dec_reg.kind == cid_pkg::K_SHL && mem_mode)
          begin
            mem_addr_reg <= ea_reg;
            mem_wr_reg <= 1'b1;
            mem_wdata_reg <= alu_res.res;
          end
          // Move copies the indexed byte into the direct page
          if (dec_reg.kind == cid_pkg::K_MOVE)
          begin
            mem_addr_reg <= {cid_pkg::DIRECT_PAGE_HI, b1_reg};
            mem_wr_reg <= 1'b1;
            mem_wdata_reg <= MEM_RDATA;
          end
          state_reg <= S_PAD;
        end
        S_PAD:
          // Hold until the documented bus cycle count has run out
          if (last_tick)
          begin
            retire_reg <= 1'b1;
            pre_reg <= 1'b0;
            bus_cnt_reg <= 3'h0;
            state_reg <= start_ok ? S_OP : S_IDLE;
          end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // Programmer's registers: execution results, or software writes while halted
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      acc_reg <= 8'h00;
      hx_reg <= 16'h0000;
      sp_reg <= cid_pkg::RST_SP;
      pc_reg <= cid_pkg::RST_PC;
      cf_reg <= cid_pkg::RST_FLAGS;
    end
    else
    begin
      if (fetch_rd)
        pc_reg <= pc_reg + cid_pkg::ONE16;
      // Writing live state under a running core would race the sequencer
      if (apb_wr && halted)
      begin
        if (PADDR == cid_pkg::REG_FLAGS)
          cf_reg <= PWDATA[7:0];
        else if (PADDR == cid_pkg::REG_ACC)
          acc_reg <= PWDATA[7:0];
        else if (PADDR == cid_pkg::REG_INDEX)
          hx_reg <= PWDATA[15:0];
        else if (PADDR == cid_pkg::REG_STACK)
          sp_reg <= PWDATA[15:0];
        else if (PADDR == cid_pkg::REG_PC)
          pc_reg <= PWDATA[15:0];
      end
      else if (state_reg == S_EXE)
      begin
        case (dec_reg.kind)
          cid_pkg::K_ADC, cid_pkg::K_ADD:
          begin
            // Mask bit is left alone
            acc_reg <= alu_res.res;
            cf_reg[cid_pkg::FLG_V] <= alu_res.v;
            cf_reg[cid_pkg::FLG_H] <= alu_res.h;
            cf_reg[cid_pkg::FLG_N] <= alu_res.n;
            cf_reg[cid_pkg::FLG_Z] <= alu_res.z;
            cf_reg[cid_pkg::FLG_C] <= alu_res.c;
          end
          cid_pkg::K_SHL:
          begin
            if (dec_reg.mode == cid_pkg::MD_INHA)
              acc_reg <= alu_res.res;
            else if (dec_reg.mode == cid_pkg::MD_INHX)
              hx_reg[7:0] <= alu_res.res;
            cf_reg[cid_pkg::FLG_V] <= alu_res.v;
            cf_reg[cid_pkg::FLG_N] <= alu_res.n;
            cf_reg[cid_pkg::FLG_Z] <= alu_res.z;
            cf_reg[cid_pkg::FLG_C] <= alu_res.c;
          end
          cid_pkg::K_STACK_ADJ:
            sp_reg <= sp_reg + cid_pkg::cid_sext(b1_reg);
          cid_pkg::K_INDEX_ADJ:
            hx_reg <= hx_reg + cid_pkg::cid_sext(b1_reg);
          cid_pkg::K_BCC:
            if (!cf_reg[cid_pkg::FLG_C])
              pc_reg <= pc_reg + cid_pkg::cid_sext(b1_reg);
          cid_pkg::K_CMPBR:
          begin
            if (acc_reg == MEM_RDATA)
              pc_reg <= pc_reg + cid_pkg::cid_sext(rel_off);
            hx_reg <= hx_reg + cid_pkg::ONE16;
          end
          cid_pkg::K_MOVE:
            hx_reg <= hx_reg + cid_pkg::ONE16;
          default:
            hx_reg <= hx_reg;
        endcase
      end
    end
  end

  // Run enable and sticky unknown opcode flag; a new fault beats a clear
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      run_reg <= 1'b0;
      bad_reg <= 1'b0;
    end
    else
    begin
      if (apb_wr && PADDR == cid_pkg::REG_CTRL)
        run_reg <= PWDATA[cid_pkg::CTRL_RUN];
      if (bad_set)
        bad_reg <= 1'b1;
      else if (apb_wr && PADDR == cid_pkg::REG_STATUS && PWDATA[cid_pkg::ST_BAD])
        bad_reg <= 1'b0;
    end
  end

  // APB address decode and read mux
  always_comb
  begin
    apb_setup = PSEL && !PENABLE;
    addr_hit = 1'b1;
    rd_mux = 32'h00000000;
    if (PADDR == cid_pkg::REG_CTRL)
      rd_mux[cid_pkg::CTRL_RUN] = run_reg;
    else if (PADDR == cid_pkg::REG_STATUS)
    begin
      rd_mux[cid_pkg::ST_BUSY] = (state_reg != S_IDLE);
      rd_mux[cid_pkg::ST_BAD] = bad_reg;
    end
    else if (PADDR == cid_pkg::REG_FLAGS)
      rd_mux[7:0] = cf_reg;
    else if (PADDR == cid_pkg::REG_ACC)
      rd_mux[7:0] = acc_reg;
    else if (PADDR == cid_pkg::REG_INDEX)
      rd_mux[15:0] = hx_reg;
    else if (PADDR == cid_pkg::REG_STACK)
      rd_mux[15:0] = sp_reg;
    else if (PADDR == cid_pkg::REG_PC)
      rd_mux[15:0] = pc_reg;
    else
      addr_hit = 1'b0;
    apb_wr = PSEL && PENABLE && PWRITE && pready_reg && addr_hit;
  end

  // APB answer: ready in the first access cycle, data and error captured at setup
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= apb_setup;
      if (apb_setup)
      begin
        pslverr_reg <= !addr_hit;
        prdata_reg <= PWRITE ? 32'h00000000 : rd_mux;
      end
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign MEM_ADDR = mem_addr_reg;
  assign MEM_RD = mem_rd_reg;
  assign MEM_WR = mem_wr_reg;
  assign MEM_WDATA = mem_wdata_reg;
  assign RETIRE = retire_reg;

endmodule

// file: cid_core_chk.sv
// Port checker for the decode core: register answer timing and execution strobes.
// Bound to cid_core; sees its top-level ports only.
`timescale 1ns/10ps
module cid_core_chk #(
  parameter int unsigned BUS_DIV = 4 // Bus divider of the watched core
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Execution strobes
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic RETIRE
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // First cycle of a transfer
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  // Instruction boundary: retire together with the next fetch
  sequence bound_s;
    RETIRE && MEM_RD;
  endsequence
  a_ready_setup: assert property (setup_s |=> PREADY) else $error("No answer after setup");
  a_ready_once: assert property (PREADY |=> !PREADY) else $error("Answer held too long");
  a_err_unmapped: assert property (PREADY && PADDR > 8'h18 |-> PSLVERR) else $error("Unmapped not refused");
  a_err_mapped: assert property (PREADY && PADDR <= 8'h18 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("Mapped access refused");
  a_write_quiet: assert property (PREADY && PWRITE |-> PRDATA == 32'h0) else $error("Data on a write");
  a_store_pulse: assert property (MEM_WR |=> !MEM_WR) else $error("Store strobe held");
  a_retire_fetch: assert property (RETIRE |-> bound_s) else $error("Retire without fetch");
  a_retire_gap: assert property (bound_s |=> !RETIRE [*3]) else $error("Retire too soon");
endmodule

bind cid_core cid_core_chk #(.BUS_DIV(BUS_DIV)) chk_u (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
  .PREADY, .PSLVERR, .MEM_RD, .MEM_WR, .RETIRE);

// file: cid_pkg.sv
// Shared constants, types and helper functions for the instruction decode core.
// Assumes a single system clock domain; all users reference items as cid_pkg::name.
package cid_pkg;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0C;
  localparam logic [7:0] REG_INDEX = 8'h10;
  localparam logic [7:0] REG_STACK = 8'h14;
  localparam logic [7:0] REG_PC = 8'h18;

  // Control and status bit positions
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_BAD = 1;

  // Condition flag bit positions
  localparam int unsigned FLG_V = 7;
  localparam int unsigned FLG_H = 4;
  localparam int unsigned FLG_I = 3;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_C = 0;

  // Reset values of the programmer's registers, the address increment and the direct page
  localparam logic [7:0] RST_FLAGS = 8'h08;
  localparam logic [15:0] RST_SP = 16'h00FF;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;

  // Opcodes
  localparam logic [7:0] OP_PREFIX_STACK = 8'h9E;
  localparam logic [7:0] OP_STACK_ADJ = 8'hA7;
  localparam logic [7:0] OP_INDEX_ADJ = 8'hAF;
  localparam logic [7:0] OP_BRANCH_CC = 8'h24;
  localparam logic [7:0] OP_SHL_DIR = 8'h38;
  localparam logic [7:0] OP_SHL_ACC = 8'h48;
  localparam logic [7:0] OP_SHL_XLO = 8'h58;
  localparam logic [7:0] OP_SHL_IX1 = 8'h68;
  localparam logic [7:0] OP_SHL_IX = 8'h78;
  localparam logic [7:0] OP_CMPBR_IXP = 8'h71;
  localparam logic [7:0] OP_CMPBR_IX1P = 8'h61;
  localparam logic [7:0] OP_MOVE_IXP = 8'h7E;
  // Add family: low nibble picks the operation, high nibble the mode
  localparam logic [3:0] LO_ADC = 4'h9;
  localparam logic [3:0] LO_ADD = 4'hB;
  localparam logic [3:0] HI_IMM = 4'hA;
  localparam logic [3:0] HI_DIR = 4'hB;
  localparam logic [3:0] HI_EXT = 4'hC;
  localparam logic [3:0] HI_IX2 = 4'hD;
  localparam logic [3:0] HI_IX1 = 4'hE;
  localparam logic [3:0] HI_IX = 4'hF;

  // Bus cycle counts per instruction form
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [2:0] CYC_5 = 3'h5;
  localparam logic [2:0] CYC_6 = 3'h6;

  // Addressing modes
  typedef enum logic [3:0] {
    MD_NONE, MD_IMM, MD_DIR, MD_EXT, MD_IX2, MD_IX1, MD_IX, MD_SP2, MD_SP1,
    MD_INHA, MD_INHX, MD_REL, MD_IXP, MD_IX1P
  } cid_mode_t;

  // Operation kinds
  typedef enum logic [3:0] {
    K_ADC, K_ADD, K_STACK_ADJ, K_INDEX_ADJ, K_SHL, K_BCC, K_CMPBR, K_MOVE, K_BAD
  } cid_kind_t;

  // Decoded instruction
  typedef struct packed {
    cid_kind_t kind;
    cid_mode_t mode;
    logic [1:0] nbytes;
    logic [2:0] cycles;
  } cid_dec_t;

  // Arithmetic result with flags
  typedef struct packed {
    logic [7:0] res;
    logic v;
    logic h;
    logic n;
    logic z;
    logic c;
  } cid_alu_t;

  // Build one decode entry
  function automatic cid_dec_t cid_entry(cid_kind_t k, cid_mode_t m, logic [1:0] nb, logic [2:0] cy);
    cid_dec_t d;
    d.kind = k;
    d.mode = m;
    d.nbytes = nb;
    d.cycles = cy;
    return d;
  endfunction

  // Opcode decode; pre marks a preceding stack prefix byte
  function automatic cid_dec_t cid_decode(logic pre, logic [7:0] op);
    cid_dec_t d;
    logic addf;
    d = cid_entry(K_BAD, MD_NONE, 2'h0, CYC_1);
    addf = (op[3:0] == LO_ADC) || (op[3:0] == LO_ADD);
    if (pre) begin
      if (op == OP_SHL_IX1) d = cid_entry(K_SHL, MD_SP1, 2'h1, CYC_6);
      else if (addf && op[7:4] == HI_IX2) d = cid_entry(K_ADD, MD_SP2, 2'h2, CYC_5);
      else if (addf && op[7:4] == HI_IX1) d = cid_entry(K_ADD, MD_SP1, 2'h1, CYC_4);
    end else begin
      if (op == OP_STACK_ADJ) d = cid_entry(K_STACK_ADJ, MD_IMM, 2'h1, CYC_2);
      else if (op == OP_INDEX_ADJ) d = cid_entry(K_INDEX_ADJ, MD_IMM, 2'h1, CYC_2);
      else if (op == OP_BRANCH_CC) d = cid_entry(K_BCC, MD_REL, 2'h1, CYC_3);
      else if (op == OP_SHL_DIR) d = cid_entry(K_SHL, MD_DIR, 2'h1, CYC_5);
      else if (op == OP_SHL_ACC) d = cid_entry(K_SHL, MD_INHA, 2'h0, CYC_1);
      else if (op == OP_SHL_XLO) d = cid_entry(K_SHL, MD_INHX, 2'h0, CYC_1);
      else if (op == OP_SHL_IX1) d = cid_entry(K_SHL, MD_IX1, 2'h1, CYC_5);
      else if (op == OP_SHL_IX) d = cid_entry(K_SHL, MD_IX, 2'h0, CYC_4);
      else if (op == OP_CMPBR_IXP) d = cid_entry(K_CMPBR, MD_IXP, 2'h1, CYC_4);
      else if (op == OP_CMPBR_IX1P) d = cid_entry(K_CMPBR, MD_IX1P, 2'h2, CYC_5);
      else if (op == OP_MOVE_IXP) d = cid_entry(K_MOVE, MD_IXP, 2'h1, CYC_4);
      else if (addf) begin
        case (op[7:4])
          HI_IMM: d = cid_entry(K_ADD, MD_IMM, 2'h1, CYC_2);
          HI_DIR: d = cid_entry(K_ADD, MD_DIR, 2'h1, CYC_3);
          HI_EXT: d = cid_entry(K_ADD, MD_EXT, 2'h2, CYC_4);
          HI_IX2: d = cid_entry(K_ADD, MD_IX2, 2'h2, CYC_4);
          HI_IX1: d = cid_entry(K_ADD, MD_IX1, 2'h1, CYC_3);
          HI_IX: d = cid_entry(K_ADD, MD_IX, 2'h0, CYC_3);
          default: d = cid_entry(K_BAD, MD_NONE, 2'h0, CYC_1);
        endcase
      end
    end
    // Same table for both add flavours, only the carry-in differs
    if (d.kind == K_ADD && op[3:0] == LO_ADC) d.kind = K_ADC;
    return d;
  endfunction

  // Sign extension of an 8-bit immediate or branch offset
  function automatic logic [15:0] cid_sext(logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

endpackage

// file: tb_cpu_isa_decode_core_subset.sv
// Bench for the decode core: register driver, byte memory, one random instruction per case.
// Assumes zero-wait register answers and memory data while each read strobe stands.
`timescale 1ns/10ps
module tb_cpu_isa_decode_core_subset;
  localparam int BD = 4; // Smallest legal bus divider, keeps runs short
  logic CLK_SYS = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0; // Bench controls
  logic [7:0] PADDR = 8'h00, MEM_RDATA, MEM_WDATA; // Bytes and offsets
  logic [31:0] PWDATA = 32'h0, PRDATA, rv; // Register data and last read
  logic PREADY, PSLVERR, MEM_RD, MEM_WR, RETIRE, se; // Core outputs and last error
  logic [15:0] MEM_ADDR; // Memory address
  logic [7:0] mem [0:65535] = '{default: 8'h00}; // Zero is a bad opcode, so the core parks after one instruction
  int num_errors = 0, n_tests = 0; // Counts
  int cyt [19] = '{2, 3, 4, 4, 3, 3, 5, 4, 2, 2, 1, 5, 3, 3, 3, 4, 5, 4, 6}; // Bus cycles
  int lnt [19] = '{2, 2, 3, 3, 2, 1, 4, 3, 2, 2, 1, 2, 2, 2, 2, 2, 3, 2, 3}; // Bytes per case
  always #20 CLK_SYS = ~CLK_SYS; // 25 MHz
  cid_core #(.BUS_DIV(BD)) dut_u (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .MEM_ADDR, .MEM_RD, .MEM_WR, .MEM_WDATA, .MEM_RDATA, .RETIRE);
  // Read data stands with the strobe; otherwise inverted so stale data never looks valid
  assign MEM_RDATA = MEM_RD ? mem[MEM_ADDR] : ~mem[MEM_ADDR];
  // Stores land at the edge that samples the write strobe
  always @(posedge CLK_SYS)
  begin
    if (MEM_WR)
      mem[MEM_ADDR] <= MEM_WDATA;
  end
  // Expected sum over expected flags
  function automatic logic [15:0] add_ref(logic [7:0] a, m, f, logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = a + m + ci;
    h = a[3:0] + m[3:0] + ci;
    return {s[7:0], (a[7] == m[7]) && (s[7] != a[7]), f[6:5], h[4], f[3], s[7], s[7:0] == 8'h00, s[8]};
  endfunction
  // Expected shift over expected flags; half-carry and mask kept
  function automatic logic [15:0] shl_ref(logic [7:0] a, f);
    return {a[6:0], 1'b0, a[7] ^ a[6], f[6:3], a[6], a[6:0] == 7'h00, a[7]};
  endfunction
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One transfer; request held until the answer edge, then released with an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do
      @(posedge CLK_SYS);
    while (PREADY !== 1'b1 && n++ < 40);
    if (PREADY !== 1'b1)
      num_errors++;
    rv = PRDATA;
    se = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  // Read and compare
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string nm);
    apb(1'b0, ad, 32'h0);
    chk(nm, e, rv);
  endtask
  // Verdict
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    logic [7:0] a, m, fl, ii;
    logic [31:0] pg;
    logic [3:0] lo;
    logic [15:0] ea, e, s, e_hx, e_sp, e_pc;
    int n;
    rv = $urandom(32'h018E42BD);
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    rd(cid_pkg::REG_FLAGS, 32'h08, "flags");
    rd(cid_pkg::REG_STACK, 32'hFF, "stack");
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    for (int k = 0; k < 19; k++)
    begin
      {a, m, fl, ii} = $urandom;
      lo = ii[0] ? cid_pkg::LO_ADC : cid_pkg::LO_ADD;
      if (k >= 12 && k <= 14)
        fl[0] = (k == 13);
      ea = 16'h8000;
      e_hx = 16'h1234;
      e_sp = 16'h0180;
      e_pc = 16'h0040 + 16'(lnt[k]);
      s = shl_ref(m, fl);
      e = k < 8 ? add_ref(a, m, fl, ii[0] & fl[0]) : {a, fl};
      // Opcode bytes, operand address and any changed expectation
      case (k)
        0: pg = {4'hA, lo, m, 16'h0};
        1: {pg, ea} = {4'hB, lo, 8'h90, 16'h0, 16'h0090};
        2: {pg, ea} = {4'hC, lo, 24'h234500, 16'h2345};
        3: {pg, ea} = {4'hD, lo, 24'hF00000, 16'h0234};
        4: {pg, ea} = {4'hE, lo, 24'hF00000, 16'h1324};
        5: {pg, ea} = {4'hF, lo, 24'h0, 16'h1234};
        6: {pg, ea} = {8'h9E, 4'hD, lo, 16'h0010, 16'h0190};
        7: {pg, ea} = {8'h9E, 4'hE, lo, 16'h8000, 16'h0200};
        8: {pg, e_sp} = {8'hA7, ii, 16'h0, 16'h0180 + {{8{ii[7]}}, ii}};
        9: {pg, e_hx} = {8'hAF, ii, 16'h0, 16'h1234 + {{8{ii[7]}}, ii}};
        10: {pg, e} = {8'h48, 24'h0, shl_ref(a, fl)};
        11: {pg, ea, e} = {8'h38, 8'h90, 16'h0, 16'h0090, a, s[7:0]};
        12: {pg, e_pc} = {8'h24, 8'h80, 16'h0, 16'hFFC2};
        13: pg = {8'h24, 8'h7F, 16'h0};
        14: {pg, e_pc} = {8'h24, 8'h7F, 16'h0, 16'h00C1};
        15: {pg, ea, e_hx} = {8'h71, 24'h0, 16'h1234, 16'h1235};
        16: {pg, ea, e_hx} = {8'h61, 24'h0, 16'h1234, 16'h1235};
        17: {pg, ea, e_hx} = {8'h7E, 8'h90, 16'h0, 16'h1234, 16'h1235};
        default: {pg, ea, e} = {8'h9E, 8'h68, 8'h10, 8'h0, 16'h0190, a, s[7:0]};
      endcase
      {mem[16'h0040], mem[16'h0041], mem[16'h0042], mem[16'h0043]} = pg;
      mem[ea] = m;
      apb(1'b1, cid_pkg::REG_ACC, {24'h0, a});
      apb(1'b1, cid_pkg::REG_FLAGS, {24'h0, fl});
      apb(1'b1, cid_pkg::REG_INDEX, 32'h1234);
      apb(1'b1, cid_pkg::REG_STACK, 32'h0180);
      apb(1'b1, cid_pkg::REG_PC, 32'h0040);
      apb(1'b1, cid_pkg::REG_CTRL, 32'h1);
      for (n = 0; MEM_RD !== 1'b1 && n < 99; n++)
        @(posedge CLK_SYS);
      for (n = 0; RETIRE !== 1'b1 && n < 99; n++)
        @(posedge CLK_SYS);
      chk("cycles", cyt[k] * BD, n);
      chk("next_pc", e_pc, MEM_ADDR);
      repeat (4 * BD) @(posedge CLK_SYS);
      apb(1'b1, cid_pkg::REG_CTRL, 32'h0);
      rd(cid_pkg::REG_CTRL, 32'h0, "run");
      rd(cid_pkg::REG_STATUS, 32'h2, "status");
      apb(1'b1, cid_pkg::REG_STATUS, 32'h2);
      rd(cid_pkg::REG_ACC, e[15:8], "acc");
      rd(cid_pkg::REG_FLAGS, e[7:0], "flags");
      rd(cid_pkg::REG_INDEX, e_hx, "index");
      rd(cid_pkg::REG_STACK, e_sp, "stack");
      if (k == 11 || k >= 17)
        chk("stored", k == 17 ? m : s[15:8], mem[k == 18 ? ea : 16'h0090]);
    end
    wrap_up();
  end
  // Watchdog, several times the expected run length
  initial
  begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule
